// ### design/ssb_port_regs.svh
// constants for the burst sram host port: reset values and lane codes
// assumes inclusion from the port module only
`ifndef SSB_PORT_REGS_SVH
`define SSB_PORT_REGS_SVH
`define SSB_LANE_ALL   4'hf
`define SSB_LANE_NONE  4'h0
`define SSB_OFF_RST    2'h0
`define SSB_OFF_STEP   2'h1
`define SSB_ADDR_RST   19'h0_0000
`define SSB_ORDER_RST  1'b1
`endif

// ### design/ssb_pkg.sv
// types shared by the burst sram host port
// assumes nothing of its surroundings
package ssb_pkg;
  typedef logic [18:0] ssb_addr_t;   // word address, 512k words
  typedef logic [3:0]  ssb_lane_t;   // one bit per byte lane, bit 0 is lane a
  typedef logic [35:0] ssb_word_t;   // {parity[3:0], data[31:0]}
  // request toward the storage core
  typedef struct packed {
    ssb_addr_t addr;
    ssb_lane_t we;
    ssb_word_t wdata;
  } ssb_core_req_s;
  // access phase of the port
  typedef enum logic [2:0] {
    SSB_IDLE  = 3'b001,
    SSB_READ  = 3'b010,
    SSB_WRITE = 3'b100
  } ssb_cyc_e;
endpackage : ssb_pkg

// ### design/ssb_port.sv
// pin-side control of a synchronous flow-through burst sram:
// address capture, burst counter, write lane qualification, data direction
// assumes the controller runs on sys_clk_in; the storage core answers
// core_rdata_in combinationally from core_req_out.addr
`timescale 1ns/10ps
`include "ssb_port_regs.svh"

module ssb_port
  import ssb_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire ssb_addr_t     addr_in,
  input  wire logic          processor_addr_strobe_n_in,
  input  wire logic          controller_addr_strobe_n_in,
  input  wire logic          select_primary_n_in,
  input  wire logic          select_expand_hi_in,
  input  wire logic          select_expand_lo_n_in,
  input  wire logic          burst_advance_n_in,
  input  wire logic          all_bytes_write_n_in,
  input  wire logic          lane_write_qualify_n_in,
  input  wire ssb_lane_t     lane_select_n_in,
  input  wire logic          output_enable_n_in,
  input  wire logic          burst_order_in,
  input  wire logic [31:0]   dq_in,
  input  wire logic [3:0]    parity_lines_in,
  output logic [31:0]        dq_out,
  output logic [3:0]         parity_lines_out,
  output logic               dq_oe_out,
  output ssb_core_req_s      core_req_out,
  input  wire ssb_word_t     core_rdata_in
);

  ////////////////////////////////////////////////////////////////////////////
  // decode of the strobes and enables
  logic       load_p;       // processor strobe accepted
  logic       load_c;       // controller strobe accepted
  logic       load;         // a new external address this edge
  logic       sel_new;      // enables sampled active
  logic       sel_nxt;      // selected after this edge
  logic       wr_ok;        // write inputs may act this edge
  ssb_lane_t  lanes_nxt;    // lanes written this edge

  // processor strobe is dead while the primary enable is high
  assign load_p  = !processor_addr_strobe_n_in && !select_primary_n_in;
  // processor strobe has priority when both are low
  assign load_c  = !load_p && !controller_addr_strobe_n_in;
  assign load    = load_p || load_c;
  assign sel_new = !select_primary_n_in && select_expand_hi_in
                   && !select_expand_lo_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser: three flops, change taken when the last two agree
  logic       ord_s1_r;
  logic       ord_s2_r;
  logic       ord_s3_r;
  logic       interleave_r; // 1: interleaved order, 0: linear

  // the strap is static, so the settling delay after reset is harmless
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ord_s1_r     <= `SSB_ORDER_RST;
      ord_s2_r     <= `SSB_ORDER_RST;
      ord_s3_r     <= `SSB_ORDER_RST;
      interleave_r <= `SSB_ORDER_RST;
    end else begin
      ord_s1_r <= burst_order_in;
      ord_s2_r <= ord_s1_r;
      ord_s3_r <= ord_s2_r;
      if (ord_s2_r == ord_s3_r) begin
        interleave_r <= ord_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection state, only touched on address loads
  logic       selected_r;   // device selected by the last load

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      selected_r <= 1'b0;
    end else if (load) begin
      selected_r <= sel_new;
    end
  end

  assign sel_nxt = load ? sel_new : selected_r;

  ////////////////////////////////////////////////////////////////////////////
  // address register and burst counter
  logic [16:0] addr_hi_r;   // upper bits, never carried into
  logic [1:0]  base_r;      // low bits captured at load
  logic [1:0]  off_r;       // burst offset
  logic [1:0]  off_nxt;
  logic [1:0]  base_nxt;
  logic [16:0] hi_nxt;
  logic [1:0]  low_nxt;

  // counter steps only inside a burst of a selected device
  always_comb begin
    hi_nxt   = addr_hi_r;
    base_nxt = base_r;
    off_nxt  = off_r;
    if (load) begin
      hi_nxt   = addr_in[18:2];
      base_nxt = addr_in[1:0];
      off_nxt  = `SSB_OFF_RST;
    end else if (selected_r && !burst_advance_n_in) begin
      off_nxt = off_r + `SSB_OFF_STEP;
    end
  end

  // two-bit offset wraps by itself; linear adds, interleaved xors
  always_comb begin
    if (interleave_r) begin
      low_nxt = base_nxt ^ off_nxt;
    end else begin
      low_nxt = base_nxt + off_nxt;
    end
  end

  // all synchronous inputs are taken on the rising edge only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      addr_hi_r <= 17'(`SSB_ADDR_RST >> 2);
      base_r    <= `SSB_OFF_RST;
      off_r     <= `SSB_OFF_RST;
    end else begin
      addr_hi_r <= hi_nxt;
      base_r    <= base_nxt;
      off_r     <= off_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write qualification
  // an address taken by the processor strobe opens a read when sel_new is set, else a deselect; the
  // write inputs of that edge are not looked at
  assign wr_ok = sel_nxt && !load_p;

  always_comb begin
    lanes_nxt = `SSB_LANE_NONE;
    if (!wr_ok) begin
      lanes_nxt = `SSB_LANE_NONE;
    end else if (!all_bytes_write_n_in) begin
      lanes_nxt = `SSB_LANE_ALL;
    end else if (!lane_write_qualify_n_in) begin
      lanes_nxt = ~lane_select_n_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request toward the core, one lane bit covers byte and parity
  ssb_core_req_s req_r;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      req_r.addr  <= `SSB_ADDR_RST;
      req_r.we    <= `SSB_LANE_NONE;
      req_r.wdata <= '0;
    end else begin
      req_r.addr  <= {hi_nxt, low_nxt};
      req_r.we    <= lanes_nxt;
      req_r.wdata <= {parity_lines_in, dq_in};
    end
  end

  assign core_req_out = req_r;

  ////////////////////////////////////////////////////////////////////////////
  // access phase and data direction
  ssb_cyc_e   cyc_r;        // phase of the current clock
  logic       drive_r;      // pins may be driven this clock

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cyc_r <= SSB_IDLE;
    end else if (!sel_nxt) begin
      cyc_r <= SSB_IDLE;
    end else if (lanes_nxt != `SSB_LANE_NONE) begin
      cyc_r <= SSB_WRITE;
    end else begin
      cyc_r <= SSB_READ;
    end
  end

  // the first read clock out of deselect stays quiet; this hides the
  // turnaround from a bus that may still be driving
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      drive_r <= 1'b0;
    end else if (!sel_nxt || lanes_nxt != `SSB_LANE_NONE) begin
      drive_r <= 1'b0;
    end else if (load && sel_new && !selected_r) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= 1'b1;
    end
  end

  // output enable acts without a clock, so this term is combinational
  assign dq_oe_out        = drive_r && !output_enable_n_in;
  assign dq_out           = core_rdata_in[31:0];
  assign parity_lines_out = core_rdata_in[35:32];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  addr_load_a: assert property (
    load && sel_new |=> core_req_out.addr == $past(addr_in))
    else $error("address not loaded on strobe");

  ce_ignore_a: assert property (
    !load |=> $stable(selected_r))
    else $error("selection changed without a load");

  strobe_block_a: assert property (
    select_primary_n_in && controller_addr_strobe_n_in |=> $stable(selected_r))
    else $error("processor strobe acted with primary enable high");

  both_strobe_a: assert property (
    load_p && !controller_addr_strobe_n_in |=> core_req_out.we == `SSB_LANE_NONE)
    else $error("controller strobe acted with processor strobe");

  burst_step_a: assert property (
    selected_r && !load && !burst_advance_n_in && !interleave_r
    ##0 $stable(interleave_r)
    |=> core_req_out.addr[1:0] == $past(core_req_out.addr[1:0]) + 2'h1
        && core_req_out.addr[18:2] == $past(core_req_out.addr[18:2]))
    else $error("linear burst step wrong");

  burst_hold_a: assert property (
    !load && burst_advance_n_in ##1 !load && burst_advance_n_in
    |=> $stable(core_req_out.addr))
    else $error("address moved without advance");

  global_wr_a: assert property (
    wr_ok && !all_bytes_write_n_in |=> core_req_out.we == `SSB_LANE_ALL)
    else $error("global write missed a lane");

  lane_wr_a: assert property (
    all_bytes_write_n_in && wr_ok
    |=> core_req_out.we == ($past(lane_write_qualify_n_in) ? `SSB_LANE_NONE
                                                           : ~$past(lane_select_n_in)))
    else $error("lane write qualification wrong");

  oe_mask_a: assert property (
    load && sel_new && !selected_r && lanes_nxt == `SSB_LANE_NONE
    |=> !dq_oe_out)
    else $error("pins driven on first read after deselect");

  tri_state_a: assert property (
    cyc_r != SSB_READ || output_enable_n_in |-> !dq_oe_out)
    else $error("pins driven outside an enabled read");

  // the clock after a write edge belongs to the data phase, pins stay off
  wr_quiet_a: assert property (
    lanes_nxt != `SSB_LANE_NONE |=> !dq_oe_out)
    else $error("pins driven in the clock after a write");

  desel_quiet_a: assert property (
    !sel_nxt |=> !dq_oe_out)
    else $error("pins driven while deselected");

  // no clock between output enable and the pins
  oe_async_a: assert property (
    output_enable_n_in |-> !dq_oe_out)
    else $error("pins driven with output enable high");

  lane_data_a: assert property (
    lanes_nxt != `SSB_LANE_NONE
    |=> core_req_out.wdata == $past({parity_lines_in, dq_in}))
    else $error("write word does not match the pins");

  // order may only follow the strap once two stages agree
  strap_sync_a: assert property (
    !$stable(interleave_r) |-> $past(ord_s2_r) == $past(ord_s3_r))
    else $error("burst order changed before the strap settled");

  burst_cov_c: cover property (
    load_p && sel_new ##1 !burst_advance_n_in [*3]);
  write_cov_c: cover property (
    load_c && sel_new && !all_bytes_write_n_in ##1 !lane_write_qualify_n_in);
  desel_cov_c: cover property (
    load && !sel_new ##1 load && sel_new ##1 dq_oe_out);
  lane_cov_c: cover property (
    wr_ok && all_bytes_write_n_in && !lane_write_qualify_n_in);

endmodule : ssb_port

// ### sim/ssb_core_model.sv
// storage core model behind the port: 16 words, lane writes at the edge
// assumes one registered request per rising edge from the port
`timescale 1ns/10ps

module ssb_core_model
  import ssb_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire ssb_core_req_s req_in,
  output ssb_word_t          rdata_out
);
  ssb_word_t mem [16];  // small window, upper address bits alias
  ////////////////////////////////////////////////////////////////////////////
  // each lane carries its data byte and its own parity bit
  always @(posedge sys_clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (req_in.we[i]) begin
        mem[req_in.addr[3:0]][8*i +: 8] <= req_in.wdata[8*i +: 8];
        mem[req_in.addr[3:0]][32+i]     <= req_in.wdata[32+i];
      end
    end
  end
  // flow-through read, stale words are kept as a real core would
  assign rdata_out = mem[req_in.addr[3:0]];
  initial begin
    for (int j = 0; j < 16; j++) mem[j] = '0;
  end
endmodule : ssb_core_model

// ### sim/ssb_port_tb.sv
// self-checking bench for the burst sram host port
// assumes ssb_pkg compiled first; results of a cycle show after the next one
`timescale 1ns/10ps

module ssb_port_tb
  import ssb_pkg::*;
();
  localparam logic [4:0] IDL = 5'h1f;  // {psn, csn, adv_n, gw_n, bwe_n}
  localparam logic [4:0] LDP = 5'h0f;  // processor strobe load
  localparam logic [4:0] LDC = 5'h17;  // controller strobe load
  localparam logic [4:0] BURST_ADVANCE_N = 5'h1b;  // burst step
  localparam logic [2:0] ON  = 3'h2;   // all three enables active
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  ssb_addr_t     addr = '0;
  logic [4:0]    ctl = IDL;             // strobes and write controls
  logic [2:0]    sel = ON;              // chip enables
  ssb_lane_t     lane_n = 4'hf;
  logic          oe_n = 1'b0;
  logic          mode = 1'b0;
  logic [31:0]   dq = 32'ha1b2_c3d4;    // pin data, constant all run
  logic [3:0]    par = 4'h5;
  logic [31:0]   dq_o;
  logic [3:0]    par_o;
  logic          oe_o;
  ssb_core_req_s req;
  ssb_word_t     rdata;
  int            error_cnt = 0;
  int            compares = 0;
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  ssb_port ssb_port_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .processor_addr_strobe_n_in(ctl[4]), .controller_addr_strobe_n_in(ctl[3]),
    .select_primary_n_in(sel[2]), .select_expand_hi_in(sel[1]),
    .select_expand_lo_n_in(sel[0]), .burst_advance_n_in(ctl[2]),
    .all_bytes_write_n_in(ctl[1]), .lane_write_qualify_n_in(ctl[0]),
    .lane_select_n_in(lane_n), .output_enable_n_in(oe_n), .burst_order_in(mode),
    .dq_in(dq), .parity_lines_in(par), .dq_out(dq_o), .parity_lines_out(par_o),
    .dq_oe_out(oe_o), .core_req_out(req), .core_rdata_in(rdata));
  ssb_core_model ssb_core_model_inst (.sys_clk_in(clk), .req_in(req),
    .rdata_out(rdata));
  ////////////////////////////////////////////////////////////////////////////
  // shared comparison; wrappers keep each result kind apart
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk_addr(input ssb_addr_t g, input ssb_addr_t e);
    cmp({17'h0, g}, {17'h0, e});
  endtask : chk_addr
  task automatic chk_lane(input ssb_lane_t g, input ssb_lane_t e);
    cmp({32'h0, g}, {32'h0, e});
  endtask : chk_lane
  task automatic chk_word(input ssb_word_t g, input ssb_word_t e);
    cmp(g, e);
  endtask : chk_word
  task automatic chk_flag(input logic g, input logic e);
    cmp({35'h0, g}, {35'h0, e});
  endtask : chk_flag
  // one bus cycle: drive at the edge, let it settle
  task automatic cyc(input logic [4:0] c, input ssb_lane_t ln, input logic [2:0] s);
    @(posedge clk);
    ctl <= c;
    lane_n <= ln;
    sel <= s;
    #1;
  endtask : cyc
  ////////////////////////////////////////////////////////////////////////////
  // burst from a deselected state in the given order, then hold and async oe
  task automatic t_burst(input logic m);
    ssb_addr_t a;
    logic [1:0] k;
    a = 19'h4_0001;
    @(posedge clk);
    mode <= m;
    addr <= a;
    cyc(LDC, 4'hf, 3'h0);  // load with expand enable low deselects
    repeat (5) cyc(IDL, 4'hf, ON);
    chk_flag(oe_o, 1'b0);
    cyc(LDP, 4'hf, ON);
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      // enables drop on one advance clock; they must not deselect
      cyc((i < 3) ? BURST_ADVANCE_N : IDL, 4'hf, (i == 1) ? 3'h0 : ON);
      chk_addr(req.addr, {a[18:2], m ? (a[1:0] ^ k) : (a[1:0] + k)});
      chk_flag(oe_o, i != 0);
    end
    cyc(IDL, 4'hf, ON);
    chk_addr(req.addr, {a[18:2], m ? 2'h2 : 2'h0});
    @(posedge clk);
    oe_n <= 1'b1;
    #1;
    chk_flag(oe_o, 1'b0);
    @(posedge clk);
    oe_n <= 1'b0;
    #1;
    chk_flag(oe_o, 1'b1);
    $display("test burst order %0d done", m);
  endtask : t_burst
  // strobe refusals: processor strobe with primary high, then both strobes
  task automatic t_strobe();
    @(posedge clk);
    addr <= 19'h0_0009;
    cyc(LDP, 4'hf, 3'h6);
    cyc(IDL, 4'hf, ON);
    chk_addr(req.addr, 19'h4_0002);
    cyc(5'h05, 4'hf, ON);
    cyc(IDL, 4'hf, ON);
    chk_addr(req.addr, 19'h0_0009);
    chk_lane(req.we, 4'h0);
    $display("test strobe done");
  endtask : t_strobe
  // global write over a lane write, lane write, unqualified lanes, read back
  task automatic t_write();
    @(posedge clk);
    addr <= 19'h0_0004;
    cyc(5'h14, 4'he, ON);  // global and lane path both asserted
    cyc(5'h1a, 4'he, ON);
    chk_lane(req.we, 4'hf);
    chk_word(req.wdata, 36'h5_a1b2_c3d4);
    cyc(BURST_ADVANCE_N, 4'he, ON);
    chk_lane(req.we, 4'h1);
    chk_flag(oe_o, 1'b0);
    cyc(IDL, 4'hf, ON);
    chk_lane(req.we, 4'h0);
    chk_addr(req.addr, 19'h0_0006);
    cyc(LDP, 4'hf, ON);
    cyc(BURST_ADVANCE_N, 4'hf, ON);
    chk_word({par_o, dq_o}, 36'h5_a1b2_c3d4);
    cyc(IDL, 4'hf, ON);
    chk_word({par_o, dq_o}, 36'h1_0000_00d4);
    $display("test write done");
  endtask : t_write
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // watchdog: the tests need well under 100 cycles
  initial begin
    repeat (1000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_burst(1'b0);
    t_burst(1'b1);
    t_strobe();
    t_write();
    summarize();
  end
endmodule : ssb_port_tb
